// ### logic/bridge_pkg.sv
// Shared constants and types for the PCI side and the ISA bus clock divisors of the ISA bridge.
package bridge_pkg;
   localparam logic [3:0] cmd_io_rd      = 4'h2;
   localparam logic [3:0] cmd_io_wr      = 4'h3;
   localparam logic [3:0] cmd_mem_rd     = 4'h6;
   localparam logic [3:0] cmd_mem_wr     = 4'h7;
   localparam logic [3:0] cmd_cfg_rd     = 4'ha;
   localparam logic [3:0] cmd_cfg_wr     = 4'hb;
   // Slow decode slot: devsel asserted when the decode count reaches this, four clocks after address.
   localparam logic [1:0] slow_slot      = 2'h2;
   // Subtractive slot: one clock after slow decode.
   localparam logic [1:0] sub_slot       = 2'h3;
   localparam logic [1:0] isa_div_three  = 2'h2;
   localparam logic [1:0] isa_div_four   = 2'h3;
   // Clocks of wait before target ready is given.
   localparam logic [3:0] data_wait      = 4'h2;
   localparam logic [31:0] read_default  = 32'hffffffff;
   localparam int         clk_mhz        = 40;
   typedef enum logic [2:0] {
      t_idle, t_decode, t_data, t_turn
   } tgt_state_t;
   typedef enum logic [2:0] {
      m_idle, m_addr, m_data, m_last, m_turn
   } mst_state_t;
endpackage

// ### logic/pci_bus_if.sv
// Interface joining the bridge target and the host-side initiator.
`timescale 1ns/1ps
interface pci_bus_if;
   logic [31:0] ad_in,    ad_out_t,   ad_out_m;
   logic        ad_oe_t,  ad_oe_m;
   logic [3:0]  cbe_b_in, cbe_b_out;
   logic        cbe_oe;
   logic        frame_b_in, frame_b_out, frame_oe;
   logic        irdy_b_in,  irdy_b_out,  irdy_oe;
   logic        trdy_b_in,  trdy_b_out,  trdy_oe;
   logic        stop_b_in,  stop_b_out,  stop_oe;
   logic        devsel_b_in, devsel_b_out, devsel_oe;
   logic        par_in, par_out_t, par_out_m, par_oe_t, par_oe_m;
   logic        serr_b_in, serr_oe_t, serr_oe_m;
   logic        other_claim_b;
   logic        idsel;
   logic        host_isa_cycle_hint;
   modport target (
      input  ad_in, cbe_b_in, frame_b_in, irdy_b_in, par_in, serr_b_in,
      input  idsel, host_isa_cycle_hint, other_claim_b,
      output ad_out_t, ad_oe_t, trdy_b_out, trdy_oe, stop_b_out, stop_oe,
      output devsel_b_out, devsel_oe, par_out_t, par_oe_t, serr_oe_t
   );
   modport initiator (
      input  ad_in, trdy_b_in, stop_b_in, devsel_b_in, par_in, serr_b_in,
      output ad_out_m, ad_oe_m, cbe_b_out, cbe_oe, frame_b_out, frame_oe,
      output irdy_b_out, irdy_oe, par_out_m, par_oe_m, serr_oe_m,
      output idsel, host_isa_cycle_hint
   );
endinterface

// ### logic/isa_bridge_target.sv
// Bridge end: PCI target with subtractive decode, parity and clocks.
`timescale 1ns/1ps
module isa_bridge_target (
   input  wire logic    clock,
   input  wire logic    rst_b,
   input  wire logic    clk_en,
   pci_bus_if.target    bus,
   input  wire logic    isolate_b,
   input  wire logic    isa_div_sel,
   input  wire logic    strap_in,
   output logic         strap_pull_down,
   output logic         isa_bus_clock,
   output logic         isa_outputs_oe,
   output logic         pclk_out,
   output logic         decoder_enabled,
   input  wire logic    parity_err_in,
   output logic         claimed_cfg,
   output logic [3:0]   claimed_cmd,
   output logic [31:0]  claimed_addr
);
   // Even parity of the 36 lines driven in one phase.
   function automatic logic even_par(input logic [31:0] d,
                                     input logic [3:0] c);
      even_par = ^{d, c};
   endfunction

   bridge_pkg::tgt_state_t st_r, st_nxt;
   logic [1:0]  slot_r, slot_nxt;
   logic [3:0]  wait_r, wait_nxt;
   logic        rd_r, rd_nxt, cfg_r, cfg_nxt;
   logic [3:0]  cmd_r, cmd_nxt;
   logic [31:0] addr_r, addr_nxt;
   logic        devsel_r, devsel_nxt, trdy_r, trdy_nxt, stop_r, stop_nxt;
   logic        adoe_r, adoe_nxt, paroe_r, paroe_nxt, par_r, par_nxt;
   logic [31:0] ad_r, ad_nxt;
   logic        serr_r, serr_nxt;
   logic        dec_en_r, dec_en_nxt, in_reset_r;
   logic [1:0]  div_r, div_nxt;
   logic        isa_clk_r, isa_clk_nxt, pclk_r;
   logic        isa_oe_r, isa_oe_nxt;
   logic        frame_start, last_phase;

   // An address phase is frame falling while the bus is idle.
   assign frame_start = !bus.frame_b_in && (st_r == bridge_pkg::t_idle);
   assign last_phase  = bus.frame_b_in;

   // Target state machine; the combinational half holds all decisions.
   always_comb begin
      st_nxt = st_r;
      slot_nxt = slot_r;
      wait_nxt = wait_r;
      rd_nxt = rd_r;
      cfg_nxt = cfg_r;
      cmd_nxt = cmd_r;
      addr_nxt = addr_r;
      devsel_nxt = devsel_r;
      trdy_nxt = 1'b1;
      stop_nxt = 1'b1;
      adoe_nxt = adoe_r;
      ad_nxt = ad_r;
      paroe_nxt = adoe_r; // Parity trails its data by one clock.
      par_nxt = even_par(ad_r, bus.cbe_b_in);
      case (st_r)
         bridge_pkg::t_idle: begin
            devsel_nxt = 1'b1;
            adoe_nxt = 1'b0;
            if (frame_start) begin
               addr_nxt = bus.ad_in;
               cmd_nxt = bus.cbe_b_in;
               cfg_nxt = (bus.cbe_b_in[3:1] == bridge_pkg::cmd_cfg_rd[3:1]);
               rd_nxt = !bus.cbe_b_in[0];
               slot_nxt = 2'h0;
               st_nxt = bridge_pkg::t_decode;
            end
         end
         bridge_pkg::t_decode: begin
            slot_nxt = slot_r + 2'h1;
            if (cfg_r && bus.idsel && slot_r == 2'h0) begin
               devsel_nxt = 1'b0;
            end else if (!cfg_r && dec_en_r && bus.host_isa_cycle_hint &&
                         bus.other_claim_b &&
                         slot_r == bridge_pkg::slow_slot) begin
               devsel_nxt = 1'b0;
            end
            if (!devsel_nxt) begin
               wait_nxt = bridge_pkg::data_wait;
               st_nxt = bridge_pkg::t_data;
               adoe_nxt = rd_r;
               ad_nxt = bridge_pkg::read_default;
            end else if (!bus.other_claim_b ||
                         slot_r == bridge_pkg::sub_slot) begin
               st_nxt = bridge_pkg::t_turn; // Another agent or nobody.
            end
         end
         bridge_pkg::t_data: begin
            if (wait_r != 4'h0) begin
               wait_nxt = wait_r - 4'h1;
            end else begin
               trdy_nxt = 1'b0;
               stop_nxt = !cfg_r ? 1'b0 : 1'b1;
            end
            if (!trdy_r && !bus.irdy_b_in) begin
               if (last_phase) begin
                  st_nxt = bridge_pkg::t_turn;
                  devsel_nxt = 1'b1;
                  adoe_nxt = 1'b0;
                  trdy_nxt = 1'b1;
                  stop_nxt = 1'b1;
               end else begin
                  wait_nxt = bridge_pkg::data_wait;
                  trdy_nxt = 1'b1;
               end
            end
         end
         bridge_pkg::t_turn: begin
            devsel_nxt = 1'b1;
            adoe_nxt = 1'b0;
            if (bus.frame_b_in && bus.irdy_b_in) begin
               st_nxt = bridge_pkg::t_idle;
            end
         end
         default: st_nxt = bridge_pkg::t_idle;
      endcase
      serr_nxt = parity_err_in; // Registered copy of the fault input, one clock later.
   end

   // Clock divider for the ISA bus clock, strap capture and ISA enable.
   always_comb begin
      isa_oe_nxt = isolate_b;
      dec_en_nxt = dec_en_r;
      if (in_reset_r) begin
         dec_en_nxt = !strap_in;
      end
      isa_clk_nxt = isa_clk_r;
      if (div_r == (isa_div_sel ? bridge_pkg::isa_div_four
                                : bridge_pkg::isa_div_three)) begin
         div_nxt = 2'h0;
      end else begin
         div_nxt = div_r + 2'h1;
      end
      if (div_r == 2'h0) begin
         isa_clk_nxt = 1'b1;
      end else if (div_r == 2'h1 + {1'b0, isa_div_sel}) begin
         isa_clk_nxt = 1'b0;
      end
   end

   // Registers; reset is synchronous and the enable freezes everything.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         st_r <= bridge_pkg::t_idle;
         slot_r <= 2'h0;
         wait_r <= 4'h0;
         rd_r <= 1'b0;
         cfg_r <= 1'b0;
         cmd_r <= 4'h0;
         addr_r <= 32'h0;
         devsel_r <= 1'b1;
         trdy_r <= 1'b1;
         stop_r <= 1'b1;
         adoe_r <= 1'b0;
         ad_r <= 32'h0;
         paroe_r <= 1'b0;
         par_r <= 1'b0;
         serr_r <= 1'b0;
         in_reset_r <= 1'b1;
         dec_en_r <= 1'b1;
         div_r <= 2'h0;
         isa_clk_r <= 1'b0;
         pclk_r <= 1'b0;
         isa_oe_r <= 1'b0;
      end else if (clk_en) begin
         st_r <= st_nxt;
         slot_r <= slot_nxt;
         wait_r <= wait_nxt;
         rd_r <= rd_nxt;
         cfg_r <= cfg_nxt;
         cmd_r <= cmd_nxt;
         addr_r <= addr_nxt;
         devsel_r <= devsel_nxt;
         trdy_r <= trdy_nxt;
         stop_r <= stop_nxt;
         adoe_r <= adoe_nxt;
         ad_r <= ad_nxt;
         paroe_r <= paroe_nxt;
         par_r <= par_nxt;
         serr_r <= serr_nxt;
         in_reset_r <= 1'b0;
         dec_en_r <= dec_en_nxt;
         div_r <= div_nxt;
         isa_clk_r <= isa_clk_nxt;
         pclk_r <= ~pclk_r;
         isa_oe_r <= isa_oe_nxt;
      end
   end

   // While isolated every enable is forced off.
   always_comb begin
      bus.ad_out_t = ad_r;
      bus.ad_oe_t = adoe_r && isolate_b;
      bus.devsel_b_out = devsel_r;
      bus.trdy_b_out = trdy_r;
      bus.stop_b_out = stop_r;
      // Strobes are driven only while claimed, so a cycle that another
      // agent takes never meets a second driver on them.
      bus.devsel_oe = (st_r == bridge_pkg::t_data) && isolate_b;
      bus.trdy_oe = bus.devsel_oe;
      bus.stop_oe = bus.devsel_oe;
      bus.par_out_t = par_r;
      bus.par_oe_t = paroe_r && isolate_b;
      bus.serr_oe_t = serr_r && isolate_b;
   end

   // Pin outputs; the clock copy runs at half rate as a divided stand-in.
   assign strap_pull_down = in_reset_r;
   assign isa_bus_clock = isa_clk_r;
   assign isa_outputs_oe = isa_oe_r;
   assign pclk_out = pclk_r;
   assign decoder_enabled = dec_en_r;
   assign claimed_cfg = cfg_r;
   assign claimed_cmd = cmd_r;
   assign claimed_addr = addr_r;
   // Operating rate is fixed at the top of the allowed range.
endmodule

// ### logic/pci_host_initiator.sv
// Host end: single-phase PCI initiator that also drives the hint.
`timescale 1ns/1ps
module pci_host_initiator (
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        clk_en,
   pci_bus_if.initiator     bus,
   input  wire logic        req_valid,
   input  wire logic [3:0]  req_cmd,
   input  wire logic [31:0] req_addr,
   input  wire logic [31:0] req_wdata,
   input  wire logic [3:0]  req_be_b,
   input  wire logic        req_isa,
   input  wire logic        req_cfg_sel,
   output logic             busy,
   output logic             done,
   output logic             aborted,
   output logic [31:0]      rdata
);
   bridge_pkg::mst_state_t st_r, st_nxt;
   logic [3:0]  cnt_r, cnt_nxt;
   logic        busy_r, done_r, done_nxt, abt_r, abt_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic        rd_op_r;
   logic [3:0]  cmd_r;
   logic [31:0] addr_r, wd_r;
   logic [3:0]  be_r;
   logic        isa_r, sel_r;

   // Initiator sequence: address, one data phase, turnaround.
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      done_nxt = 1'b0;
      abt_nxt = 1'b0;
      rd_nxt = rd_r;
      case (st_r)
         bridge_pkg::m_idle: if (req_valid) st_nxt = bridge_pkg::m_addr;
         bridge_pkg::m_addr: begin
            st_nxt = bridge_pkg::m_last;
            cnt_nxt = 4'h0;
         end
         bridge_pkg::m_last: begin
            cnt_nxt = cnt_r + 4'h1;
            if (!bus.trdy_b_in) begin
               rd_nxt = bus.ad_in;
               done_nxt = 1'b1;
               st_nxt = bridge_pkg::m_turn;
            end else if (cnt_r == 4'h8 && bus.devsel_b_in) begin
               abt_nxt = 1'b1; // Master abort: nobody claimed.
               st_nxt = bridge_pkg::m_turn;
            end
         end
         bridge_pkg::m_turn: st_nxt = bridge_pkg::m_idle;
         default: st_nxt = bridge_pkg::m_idle;
      endcase
   end

   // Registers with synchronous reset and freezing clock enable.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         st_r <= bridge_pkg::m_idle;
         cnt_r <= 4'h0;
         done_r <= 1'b0;
         abt_r <= 1'b0;
         rd_r <= 32'h0;
         busy_r <= 1'b0;
         rd_op_r <= 1'b0;
         cmd_r <= 4'h0;
         addr_r <= 32'h0;
         wd_r <= 32'h0;
         be_r <= 4'hf;
         isa_r <= 1'b0;
         sel_r <= 1'b0;
      end else if (clk_en) begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         done_r <= done_nxt;
         abt_r <= abt_nxt;
         rd_r <= rd_nxt;
         busy_r <= (st_nxt != bridge_pkg::m_idle);
         if (st_r == bridge_pkg::m_idle && req_valid) begin
            cmd_r <= req_cmd;
            addr_r <= req_addr;
            wd_r <= req_wdata;
            be_r <= req_be_b;
            isa_r <= req_isa;
            sel_r <= req_cfg_sel;
            rd_op_r <= !req_cmd[0];
         end
      end
   end

   // Bus drive: one data phase, so frame drops with irdy.
   always_comb begin
      bus.frame_oe = (st_r == bridge_pkg::m_addr) ||
                     (st_r == bridge_pkg::m_last);
      bus.frame_b_out = !(st_r == bridge_pkg::m_addr);
      bus.irdy_oe = bus.frame_oe || (st_r == bridge_pkg::m_turn);
      bus.irdy_b_out = !(st_r == bridge_pkg::m_last);
      bus.cbe_oe = bus.frame_oe;
      bus.cbe_b_out = (st_r == bridge_pkg::m_addr) ? cmd_r : be_r;
      bus.ad_oe_m = (st_r == bridge_pkg::m_addr) ||
                    (st_r == bridge_pkg::m_last && !rd_op_r);
      bus.ad_out_m = (st_r == bridge_pkg::m_addr) ? addr_r : wd_r;
      bus.par_out_m = ^{bus.ad_out_m, bus.cbe_b_out};
      bus.par_oe_m = 1'b0;
      bus.serr_oe_m = 1'b0;
      bus.idsel = sel_r && busy_r;
      bus.host_isa_cycle_hint = isa_r && busy_r;
   end

   assign busy = busy_r;
   assign done = done_r;
   assign aborted = abt_r;
   assign rdata = rd_r;
endmodule

// ### verif/bridge_sva.sv
// Timing checker for the bus between host initiator and bridge target.
`timescale 1ns/1ps
module bridge_sva (
   input wire logic        clock,
   input wire logic        rst_b,
   input wire logic [31:0] ad_in,
   input wire logic [3:0]  cbe_b_in,
   input wire logic        frame_b_in,
   input wire logic        ad_oe_m,
   input wire logic        cbe_oe,
   input wire logic        idsel,
   input wire logic        host_isa_cycle_hint,
   input wire logic        other_claim_b,
   input wire logic        decoder_enabled,
   input wire logic        isolate_b,
   input wire logic        ad_oe_t,
   input wire logic        devsel_b_out,
   input wire logic        devsel_oe,
   input wire logic        trdy_b_out,
   input wire logic        trdy_oe,
   input wire logic        stop_b_out,
   input wire logic        stop_oe,
   input wire logic        par_out_t,
   input wire logic        par_oe_t,
   input wire logic        serr_oe_t
);
   // A strobe counts only while driven low; a released line is never on.
   wire dev_on  = devsel_oe & ~devsel_b_out;
   wire trdy_on = trdy_oe & ~trdy_b_out;
   wire stop_on = stop_oe & ~stop_b_out;
   wire is_cfg  = (cbe_b_in == bridge_pkg::cmd_cfg_rd) ||
                  (cbe_b_in == bridge_pkg::cmd_cfg_wr);
   // An isolated target may decide to claim but shows nothing on the bus.
   wire sub_ok  = host_isa_cycle_hint & decoder_enabled & other_claim_b &
                  isolate_b;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   // Address phases, sorted by the claim each one should get.
   sequence s_addr;
      $fell(frame_b_in);
   endsequence
   sequence s_cfg_hit;
      s_addr ##0 (is_cfg && idsel && isolate_b);
   endsequence
   sequence s_cfg_miss;
      s_addr ##0 (is_cfg && !(idsel && isolate_b));
   endsequence
   sequence s_sub_hit;
      s_addr ##0 (!is_cfg && sub_ok);
   endsequence
   sequence s_sub_miss;
      s_addr ##0 (!is_cfg && !sub_ok);
   endsequence

   a_addr_with_frame: assert property (s_addr |-> ad_oe_m && cbe_oe)
      else $error("address or command not driven with frame");
   a_cfg_claim_slot: assert property (s_cfg_hit |-> !devsel_oe[*2] ##1 dev_on)
      else $error("config claim not in its slot");
   a_cfg_no_idsel: assert property (s_cfg_miss |=> !devsel_oe[*8])
      else $error("config claimed without idsel");
   a_sub_claim_slot: assert property (s_sub_hit |-> !devsel_oe[*4] ##1 dev_on)
      else $error("subtractive claim not in its slot");
   a_sub_refused: assert property (s_sub_miss |=> !devsel_oe[*8])
      else $error("claim taken when not permitted");
   a_trdy_after_dev: assert property ($rose(dev_on) |-> !trdy_on[*3] ##1 trdy_on)
      else $error("target ready not three clocks after claim");
   a_trdy_one_clk: assert property (trdy_on |=> !trdy_on)
      else $error("target ready held too long");
   a_stop_with_trdy: assert property (stop_on |-> trdy_on && dev_on)
      else $error("stop outside a claimed data phase");
   a_even_parity: assert property
      (par_oe_t |-> par_out_t == ^{$past(ad_in), $past(cbe_b_in)})
      else $error("parity not even");
   a_serr_pulse: assert property (serr_oe_t |=> !serr_oe_t)
      else $error("system error not a pulse");
   a_isolate_off: assert property (!isolate_b |->
      !(ad_oe_t || devsel_oe || trdy_oe || stop_oe || par_oe_t))
      else $error("bus driven while isolated");
   a_reset_idle: assert property (disable iff (1'b0)
      !rst_b |=> !(devsel_oe || trdy_oe || ad_oe_t || serr_oe_t))
      else $error("bus driven after reset");
endmodule

// ### verif/tb_top.sv
// Testbench joining host initiator and bridge target across the bus.
`timescale 1ns/1ps
module tb_top;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic        clk_en = 1'b1;
   logic        isolate_b = 1'b1;
   logic        isa_div_sel = 1'b0;
   logic        strap_in = 1'b0;
   logic        parity_err_in = 1'b0;
   logic        oclaim_b = 1'b1;
   logic        req_valid = 1'b0;
   logic        req_isa = 1'b0;
   logic        req_cfg_sel = 1'b0;
   logic [3:0]  req_cmd = 4'h0;
   logic [3:0]  req_be_b = 4'h0;
   logic [31:0] req_addr = 32'h0;
   logic [31:0] req_wdata = 32'h0;
   logic [31:0] pat = 32'h0;
   logic        strap_pull_down, isa_bus_clock, isa_outputs_oe, pclk_out;
   logic        decoder_enabled, claimed_cfg, busy, done, aborted, got_done;
   logic [3:0]  claimed_cmd;
   logic [31:0] claimed_addr, rdata;
   int          error_cnt = 0;
   int          n_compared = 0;

   pci_bus_if pci ();

   // Clock and an idle pattern that changes each cycle on undriven lines.
   always #(500.0 / bridge_pkg::clk_mhz) clock = ~clock;
   always @(posedge clock) pat <= pat + 32'h9e3779b9;

   // Wire resolution; the strobes and the error line have pull-ups.
   assign pci.ad_in = pci.ad_oe_t ? pci.ad_out_t :
                      pci.ad_oe_m ? pci.ad_out_m : pat;
   assign pci.cbe_b_in = pci.cbe_oe ? pci.cbe_b_out : pat[7:4];
   assign pci.par_in = pci.par_oe_t ? pci.par_out_t :
                       pci.par_oe_m ? pci.par_out_m : pat[9];
   assign pci.frame_b_in = pci.frame_oe ? pci.frame_b_out : 1'b1;
   assign pci.irdy_b_in = pci.irdy_oe ? pci.irdy_b_out : 1'b1;
   assign pci.trdy_b_in = pci.trdy_oe ? pci.trdy_b_out : 1'b1;
   assign pci.stop_b_in = pci.stop_oe ? pci.stop_b_out : 1'b1;
   assign pci.devsel_b_in = pci.devsel_oe ? pci.devsel_b_out : 1'b1;
   assign pci.serr_b_in = ~(pci.serr_oe_t | pci.serr_oe_m);
   assign pci.other_claim_b = oclaim_b;

   isa_bridge_target i_isa_bridge_target (.clock(clock), .rst_b(rst_b),
      .clk_en(clk_en), .bus(pci), .isolate_b(isolate_b),
      .isa_div_sel(isa_div_sel), .strap_in(strap_in),
      .strap_pull_down(strap_pull_down), .isa_bus_clock(isa_bus_clock),
      .isa_outputs_oe(isa_outputs_oe), .pclk_out(pclk_out),
      .decoder_enabled(decoder_enabled), .parity_err_in(parity_err_in),
      .claimed_cfg(claimed_cfg), .claimed_cmd(claimed_cmd),
      .claimed_addr(claimed_addr));
   pci_host_initiator i_pci_host_initiator (.clock(clock), .rst_b(rst_b),
      .clk_en(clk_en), .bus(pci), .req_valid(req_valid), .req_cmd(req_cmd),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_be_b(req_be_b),
      .req_isa(req_isa), .req_cfg_sel(req_cfg_sel), .busy(busy),
      .done(done), .aborted(aborted), .rdata(rdata));
   bridge_sva i_bridge_sva (.clock(clock), .rst_b(rst_b),
      .ad_in(pci.ad_in), .cbe_b_in(pci.cbe_b_in),
      .frame_b_in(pci.frame_b_in), .ad_oe_m(pci.ad_oe_m),
      .cbe_oe(pci.cbe_oe), .idsel(pci.idsel),
      .host_isa_cycle_hint(pci.host_isa_cycle_hint),
      .other_claim_b(pci.other_claim_b), .decoder_enabled(decoder_enabled),
      .isolate_b(isolate_b), .ad_oe_t(pci.ad_oe_t),
      .devsel_b_out(pci.devsel_b_out), .devsel_oe(pci.devsel_oe),
      .trdy_b_out(pci.trdy_b_out), .trdy_oe(pci.trdy_oe),
      .stop_b_out(pci.stop_b_out), .stop_oe(pci.stop_oe),
      .par_out_t(pci.par_out_t), .par_oe_t(pci.par_oe_t),
      .serr_oe_t(pci.serr_oe_t));

   task automatic wrap_up;
      if (error_cnt == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One transfer; a turnaround gap first, then wait for done or abort.
   task automatic txn(input logic [3:0] c, input logic isa, input logic sel);
      int n;
      repeat (3) @(posedge clock);
      req_cmd <= c;
      req_addr <= {28'h00c0123, c};
      req_wdata <= 32'h5a5a0f0f;
      req_isa <= isa;
      req_cfg_sel <= sel;
      req_valid <= 1'b1;
      @(posedge clock);
      req_valid <= 1'b0;
      n = 0;
      while (n < 30 && done !== 1'b1 && aborted !== 1'b1) begin
         @(negedge clock);
         n++;
      end
      got_done = done;
      chk_word({31'h0, n < 30}, 32'h1);
   endtask

   // Reset with a given strap; the pull-down shows only inside reset.
   task automatic do_reset(input logic s);
      @(posedge clock);
      rst_b <= 1'b0;
      strap_in <= s;
      repeat (4) @(posedge clock);
      @(negedge clock) chk_word({31'h0, strap_pull_down}, 32'h1);
      @(posedge clock);
      rst_b <= 1'b1;
      repeat (3) @(negedge clock);
      chk_word({31'h0, decoder_enabled}, {31'h0, ~s});
      chk_word({31'h0, busy}, 32'h0);
      chk_word({31'h0, strap_pull_down}, 32'h0);
   endtask

   // Both config commands with idsel, then a read without it.
   task automatic t_cfg;
      txn(bridge_pkg::cmd_cfg_wr, 1'b0, 1'b1);
      chk_word({31'h0, claimed_cfg}, 32'h1);
      chk_word(claimed_addr, {28'h00c0123, bridge_pkg::cmd_cfg_wr});
      txn(bridge_pkg::cmd_cfg_rd, 1'b0, 1'b1);
      chk_word({28'h0, claimed_cmd}, {28'h0, bridge_pkg::cmd_cfg_rd});
      chk_word(rdata, bridge_pkg::read_default);
      txn(bridge_pkg::cmd_cfg_rd, 1'b0, 1'b0);
      chk_word({31'h0, got_done}, 32'h0);
   endtask

   // Every other command claimed with the hint; refused without it.
   task automatic t_sub;
      logic [3:0] cmds [4];
      cmds = '{bridge_pkg::cmd_io_rd, bridge_pkg::cmd_io_wr,
               bridge_pkg::cmd_mem_rd, bridge_pkg::cmd_mem_wr};
      foreach (cmds[i]) begin
         txn(cmds[i], 1'b1, 1'b0);
         chk_word({31'h0, got_done}, 32'h1);
         chk_word({28'h0, claimed_cmd}, {28'h0, cmds[i]});
      end
      txn(bridge_pkg::cmd_mem_rd, 1'b0, 1'b0);
      chk_word({31'h0, got_done}, 32'h0);
      @(posedge clock) oclaim_b <= 1'b0;
      txn(bridge_pkg::cmd_io_rd, 1'b1, 1'b0);
      chk_word({31'h0, got_done}, 32'h0);
      @(posedge clock) oclaim_b <= 1'b1;
   endtask

   // Isolation takes the ISA side off and keeps the bus untouched.
   task automatic t_isolate;
      @(posedge clock) isolate_b <= 1'b0;
      repeat (2) @(negedge clock);
      chk_word({31'h0, isa_outputs_oe}, 32'h0);
      txn(bridge_pkg::cmd_io_rd, 1'b1, 1'b0);
      chk_word({31'h0, got_done}, 32'h0);
      @(posedge clock) isolate_b <= 1'b1;
      repeat (2) @(negedge clock);
      chk_word({31'h0, isa_outputs_oe}, 32'h1);
   endtask

   // ISA clock period for both divisors, and the half-rate clock copy.
   task automatic t_clocks;
      int t0;
      int i;
      logic last;
      for (int d = 0; d < 2; d++) begin
         @(posedge clock) isa_div_sel <= d[0];
         repeat (12) @(negedge clock);
         t0 = -1;
         last = isa_bus_clock;
         for (i = 0; i < 40; i++) begin
            @(negedge clock);
            if (isa_bus_clock === 1'b1 && last === 1'b0) begin
               if (t0 >= 0) break;
               t0 = i;
            end
            last = isa_bus_clock;
         end
         chk_word(32'(i - t0), d ? 32'h4 : 32'h3);
      end
      last = pclk_out;
      @(negedge clock) chk_word({31'h0, pclk_out}, {31'h0, ~last});
      @(posedge clock) clk_en <= 1'b0;
      @(negedge clock) last = pclk_out;
      @(negedge clock) chk_word({31'h0, pclk_out}, {31'h0, last});
      @(posedge clock) clk_en <= 1'b1;
   endtask

   // A detected error gives one clock of system error on the wire.
   task automatic t_serr;
      @(posedge clock) parity_err_in <= 1'b1;
      @(posedge clock) parity_err_in <= 1'b0;
      @(negedge clock) chk_word({31'h0, pci.serr_b_in}, 32'h0);
      @(negedge clock) chk_word({31'h0, pci.serr_b_in}, 32'h1);
   endtask

   // Strap fitted high: the decoder stays off until reset with it low.
   task automatic t_strap;
      do_reset(1'b1);
      txn(bridge_pkg::cmd_io_wr, 1'b1, 1'b0);
      chk_word({31'h0, got_done}, 32'h0);
      do_reset(1'b0);
      txn(bridge_pkg::cmd_io_wr, 1'b1, 1'b0);
      chk_word({31'h0, got_done}, 32'h1);
   endtask

   // Main sequence.
   initial begin
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      do_reset(1'b0);
      t_cfg;
      t_sub;
      t_isolate;
      t_clocks;
      t_serr;
      t_strap;
      wrap_up;
   end

   // Watchdog well beyond the few hundred cycles the tests need.
   initial begin
      repeat (5000) @(posedge clock);
      error_cnt++;
      wrap_up;
   end
endmodule
